// *** rtl/bsc_pkg.sv ***
// Package of constants and types for the brake and stop selection control
package bsc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [7:0] OFS_DC_BRAKE = 8'h00;
  localparam logic [7:0] OFS_MOTOR = 8'h04;
  localparam logic [7:0] OFS_REGEN_SEL = 8'h08;
  localparam logic [7:0] OFS_SPEC_DUTY = 8'h0C;
  localparam logic [7:0] OFS_STOP_SEL = 8'h10;
  localparam logic [7:0] OFS_TERM_SEL = 8'h14;
  localparam logic [7:0] OFS_USER_GRP = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_STATE = 8'h24;
  // Reset values and limits
  localparam logic [15:0] RST_DC_BRAKE = 16'h0004;
  localparam logic [15:0] RST_STOP_SEL = 16'h270F;
  localparam logic [15:0] RST_TERM_SEL = 16'h0007;
  localparam logic [15:0] PCT_MAX = 16'h001E;
  localparam logic [15:0] PCT_2 = 16'h0002;
  localparam logic [15:0] PCT_4 = 16'h0004;
  localparam logic [4:0] FIXED_DUTY_3 = 5'h03;
  localparam logic [4:0] FIXED_DUTY_2 = 5'h02;
  localparam logic [15:0] STOP_DECEL_A = 16'h270F;
  localparam logic [15:0] STOP_DECEL_B = 16'h22B8;
  localparam logic [15:0] STOP_TIME_MAX = 16'h0064;
  localparam logic [15:0] STOP_OFS_LO = 16'h03E8;
  localparam logic [15:0] STOP_OFS_HI = 16'h044C;
  localparam logic [15:0] TERM_POS = 16'h0007;
  localparam logic [15:0] TERM_NEG = 16'h006B;
  localparam logic [15:0] REGEN_SEL_MAX = 16'h0001;
  // Status bit positions
  localparam int ST_ALARM = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_SHUT = 2;
  localparam int ST_REFUSE = 3;
  localparam int ST_W = 4;
  // Alarm threshold as a ratio: on*20 >= duty*17 is 85 percent
  localparam logic [11:0] ALARM_NUM = 12'h011;
  localparam logic [11:0] ALARM_DEN = 12'h014;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [16:0] MS_PER_S = 17'h003E8;
  localparam int WIN_TICKS = 100;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_DECEL = 3'b010,
    ST_DELAY = 3'b011,
    ST_COAST = 3'b100
  } bsc_state_t;
  typedef struct packed {
    logic alarm;
    logic fault;
  } bsc_duty_st_t;
endpackage

// *** rtl/bsc_coast_timer.sv ***
// Coast delay timer counting whole seconds on a millisecond tick
`timescale 1ns/10ps
module bsc_coast_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic clear_i,
  input wire logic [6:0] sec_i,
  output logic done_o
);
  import bsc_pkg::*;
  logic busy_reg;
  logic [16:0] left_reg;
  // Clear wins over start so a reasserted run command always cancels
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      left_reg <= 17'h00000;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (clear_i) begin
        busy_reg <= 1'b0;
      end else if (start_i) begin
        busy_reg <= 1'b1;
        left_reg <= 17'({10'h000, sec_i} * MS_PER_S);
      end else if (busy_reg && left_reg == 17'h00000) begin
        busy_reg <= 1'b0;
        done_o <= 1'b1;
      end else if (busy_reg && tick_i) begin
        left_reg <= left_reg - 17'h00001;
      end
    end
  end
endmodule // bsc_coast_timer

// *** rtl/bsc_duty_monitor.sv ***
// Regenerative brake duty monitor over a fixed window of ticks, restarted at each window end
`timescale 1ns/10ps
module bsc_duty_monitor #(
  parameter int WIN = bsc_pkg::WIN_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic active_i,
  input wire logic [4:0] duty_i,
  output bsc_pkg::bsc_duty_st_t st_o
);
  import bsc_pkg::*;
  if (WIN != 100) begin : g_chk
    $error("Window must be 100 ticks so a tick count equals a percent");
  end
  logic [6:0] win_reg;
  logic [6:0] on_reg;
  wire win_end = tick_i && (win_reg == 7'(WIN - 1));
  wire duty_on = duty_i != 5'h00;
  wire alarm_hit = duty_on && ({5'h00, on_reg} * ALARM_DEN >= {7'h00, duty_i} * ALARM_NUM);
  wire fault_hit = duty_on && (on_reg >= {2'b00, duty_i});
  // Fault is sticky until reset; alarm follows the current window
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_reg <= 7'h00;
      on_reg <= 7'h00;
      st_o <= '0;
    end else begin
      if (tick_i) begin
        win_reg <= win_end ? 7'h00 : win_reg + 7'h01;
        on_reg <= win_end ? 7'h00 : on_reg + {6'h00, active_i};
      end
      st_o.alarm <= alarm_hit;
      st_o.fault <= st_o.fault | fault_hit;
    end
  end
endmodule // bsc_duty_monitor

// *** rtl/bsc_top.sv ***
// Brake voltage, regenerative duty and stop selection control
`timescale 1ns/10ps
module bsc_top #(
  parameter int TICK_CYCLES = bsc_pkg::TICK_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic [bsc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [bsc_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [bsc_pkg::DATA_W-1:0] RDATA_O,
  input wire logic RATING_MID_I,
  input wire logic MODEL_DUTY2_I,
  input wire logic FORWARD_START_CMD_I,
  input wire logic REVERSE_START_CMD_I,
  input wire logic POWER_FAIL_STOP_I,
  input wire logic PANEL_STOP_I,
  input wire logic COMM_ERR_STOP_I,
  input wire logic MOTOR_STOPPED_I,
  input wire logic REGEN_ACTIVE_I,
  output logic OUTPUT_ENABLE_O,
  output logic RUN_STATUS_O,
  output logic DECEL_REQ_O,
  output logic FREQ_FOLLOW_O,
  output logic RESTART_START_FREQ_O,
  output logic REGEN_DUTY_ALARM_OUT_O,
  output logic REGEN_DUTY_PANEL_INDICATION_O,
  output logic REGEN_OVERVOLTAGE_FAULT_O,
  output logic OPEN_COLLECTOR_OUTPUT_TERMINAL_O,
  output logic IRQ_O
);
  import bsc_pkg::*;
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  // Motor class decode, used for old and new code alike
  function automatic logic is_std(input logic [15:0] c);
    return c == 16'h0000 || (c >= 16'h0003 && c <= 16'h0006) || c == 16'h0017 ||
      c == 16'h0018 || c == 16'h0028 || c == 16'h002B || c == 16'h002C;
  endfunction
  function automatic logic is_ct(input logic [15:0] c);
    return c == 16'h0001 || (c >= 16'h000D && c <= 16'h0010) || c == 16'h0032 ||
      c == 16'h0035 || c == 16'h0036;
  endfunction

  logic [15:0] dc_brake_voltage_setting_reg;
  logic [15:0] applied_motor_select_reg;
  logic [15:0] regen_function_select_reg;
  logic [15:0] special_regen_duty_reg;
  logic [15:0] stop_method_select_reg;
  logic [15:0] output_terminal_function_select_reg;
  logic [15:0] user_group_read_select_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  bsc_state_t state_reg;
  bsc_state_t state_next;
  logic start_q_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic alarm_q_reg;
  bsc_duty_st_t duty_st;
  logic timer_done;

  // Bus decode
  wire wr_brake = WR_I && ADDR_I == OFS_DC_BRAKE;
  wire wr_motor = WR_I && ADDR_I == OFS_MOTOR;
  wire wr_rsel = WR_I && ADDR_I == OFS_REGEN_SEL;
  wire wr_duty = WR_I && ADDR_I == OFS_SPEC_DUTY;
  wire wr_stop = WR_I && ADDR_I == OFS_STOP_SEL;
  wire wr_term = WR_I && ADDR_I == OFS_TERM_SEL;
  wire wr_ugrp = WR_I && ADDR_I == OFS_USER_GRP;
  wire wr_mask = WR_I && ADDR_I == OFS_MASK;
  wire rd_stat = RD_I && ADDR_I == OFS_STATUS;
  wire unlocked = user_group_read_select_reg == 16'h0000;

  // Acceptance of each guarded setting
  wire wd_pct = WDATA_I <= PCT_MAX;
  wire wd_stop = WDATA_I <= STOP_TIME_MAX || WDATA_I == STOP_DECEL_A ||
    WDATA_I == STOP_DECEL_B || (WDATA_I >= STOP_OFS_LO && WDATA_I <= STOP_OFS_HI);
  wire ok_brake = wr_brake && unlocked && wd_pct;
  wire ok_rsel = wr_rsel && unlocked && WDATA_I <= REGEN_SEL_MAX;
  wire ok_duty = wr_duty && unlocked && wd_pct;
  wire ok_stop = wr_stop && unlocked && wd_stop;
  wire refused = (wr_brake && !ok_brake) || (wr_rsel && !ok_rsel) ||
    (wr_duty && !ok_duty) || (wr_stop && !ok_stop);

  // Automatic brake voltage follow-up on motor class change
  wire to_ct = RATING_MID_I && dc_brake_voltage_setting_reg == PCT_4 &&
    is_std(applied_motor_select_reg) && is_ct(WDATA_I);
  wire to_std = RATING_MID_I && dc_brake_voltage_setting_reg == PCT_2 &&
    is_ct(applied_motor_select_reg) && is_std(WDATA_I);

  // Settings register file
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dc_brake_voltage_setting_reg <= RST_DC_BRAKE;
      applied_motor_select_reg <= 16'h0000;
      regen_function_select_reg <= 16'h0000;
      special_regen_duty_reg <= 16'h0000;
      stop_method_select_reg <= RST_STOP_SEL;
      output_terminal_function_select_reg <= RST_TERM_SEL;
      user_group_read_select_reg <= 16'h0000;
      mask_reg <= '0;
    end else begin
      if (ok_brake) dc_brake_voltage_setting_reg <= WDATA_I;
      else if (wr_motor && to_ct) dc_brake_voltage_setting_reg <= PCT_2;
      else if (wr_motor && to_std) dc_brake_voltage_setting_reg <= PCT_4;
      if (wr_motor) applied_motor_select_reg <= WDATA_I;
      if (ok_rsel) regen_function_select_reg <= WDATA_I;
      if (ok_duty) special_regen_duty_reg <= WDATA_I;
      if (ok_stop) stop_method_select_reg <= WDATA_I;
      if (wr_term) output_terminal_function_select_reg <= WDATA_I;
      if (wr_ugrp) user_group_read_select_reg <= WDATA_I;
      if (wr_mask) mask_reg <= WDATA_I[ST_W-1:0];
    end
  end

  // Effective duty: fixed per model when select is 0
  wire [4:0] fixed_duty = MODEL_DUTY2_I ? FIXED_DUTY_2 : FIXED_DUTY_3;
  wire [4:0] duty_eff = regen_function_select_reg == 16'h0000 ?
    fixed_duty : special_regen_duty_reg[4:0];

  // Millisecond time base shared by duty window and coast timer
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
      tick_cnt_reg <= tick_cnt_reg == 32'(TICK_CYCLES - 1) ? 32'h00000000 :
        tick_cnt_reg + 32'h00000001;
    end
  end

  bsc_duty_monitor u_duty (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .tick_i(tick_reg),
    .active_i(REGEN_ACTIVE_I),
    .duty_i(duty_eff),
    .st_o(duty_st)
  );

  // Stop selection decode
  wire start = FORWARD_START_CMD_I || REVERSE_START_CMD_I;
  wire start_fall = start_q_reg && !start;
  wire override = POWER_FAIL_STOP_I || PANEL_STOP_I || COMM_ERR_STOP_I;
  wire sel_decel = stop_method_select_reg == STOP_DECEL_A ||
    stop_method_select_reg == STOP_DECEL_B;
  wire [15:0] delay_full = stop_method_select_reg >= STOP_OFS_LO ?
    stop_method_select_reg - STOP_OFS_LO : stop_method_select_reg;
  wire [6:0] delay_s = delay_full[6:0];
  wire decel_path = sel_decel || override;
  wire fault = duty_st.fault;
  wire timer_start = state_reg == ST_RUN && start_fall && !decel_path && !fault;
  wire timer_clear = start || override;
  wire shutoff = state_next == ST_COAST && state_reg != ST_COAST;

  // Run sequence; the alarm is deliberately not an input here
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start && !fault) state_next = ST_RUN;
      ST_RUN: begin
        if (fault) state_next = ST_COAST;
        else if (start_fall && decel_path) state_next = ST_DECEL;
        else if (start_fall) state_next = ST_DELAY;
      end
      ST_DECEL: begin
        if (fault) state_next = ST_COAST;
        else if (start && !override) state_next = ST_RUN;
        else if (MOTOR_STOPPED_I) state_next = ST_IDLE;
      end
      ST_DELAY: begin
        if (fault) state_next = ST_COAST;
        else if (override) state_next = ST_DECEL;
        else if (start) state_next = ST_RUN;
        else if (timer_done) state_next = ST_COAST;
      end
      ST_COAST: begin
        if (start && !fault) state_next = ST_RUN;
        else if (MOTOR_STOPPED_I) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  bsc_coast_timer u_timer (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .tick_i(tick_reg),
    .start_i(timer_start),
    .clear_i(timer_clear),
    .sec_i(delay_s),
    .done_o(timer_done)
  );

  // Panel indication off in plain resistor mode
  wire panel_ind = duty_st.alarm && regen_function_select_reg != 16'h0000;
  wire term_val = output_terminal_function_select_reg == TERM_POS ? duty_st.alarm :
    output_terminal_function_select_reg == TERM_NEG ? !duty_st.alarm : 1'b0;
  wire [ST_W-1:0] ev = {refused, shutoff, fault && !REGEN_OVERVOLTAGE_FAULT_O,
    duty_st.alarm && !alarm_q_reg};

  // State, outputs and sticky status; a new event wins over a read clear
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg <= ST_IDLE;
      start_q_reg <= 1'b0;
      alarm_q_reg <= 1'b0;
      status_reg <= '0;
      OUTPUT_ENABLE_O <= 1'b0;
      RUN_STATUS_O <= 1'b0;
      DECEL_REQ_O <= 1'b0;
      FREQ_FOLLOW_O <= 1'b0;
      RESTART_START_FREQ_O <= 1'b0;
      REGEN_DUTY_ALARM_OUT_O <= 1'b0;
      REGEN_DUTY_PANEL_INDICATION_O <= 1'b0;
      REGEN_OVERVOLTAGE_FAULT_O <= 1'b0;
      OPEN_COLLECTOR_OUTPUT_TERMINAL_O <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_q_reg <= start;
      alarm_q_reg <= duty_st.alarm;
      status_reg <= (rd_stat ? '0 : status_reg) | ev;
      OUTPUT_ENABLE_O <= state_next inside {ST_RUN, ST_DECEL, ST_DELAY};
      RUN_STATUS_O <= state_next inside {ST_RUN, ST_DECEL, ST_DELAY};
      DECEL_REQ_O <= state_next == ST_DECEL;
      FREQ_FOLLOW_O <= state_next inside {ST_RUN, ST_DELAY};
      RESTART_START_FREQ_O <= state_reg == ST_COAST && state_next == ST_RUN;
      REGEN_DUTY_ALARM_OUT_O <= duty_st.alarm;
      REGEN_DUTY_PANEL_INDICATION_O <= panel_ind;
      REGEN_OVERVOLTAGE_FAULT_O <= fault;
      OPEN_COLLECTOR_OUTPUT_TERMINAL_O <= term_val;
    end
  end

  // Read mux; unmapped addresses read zero
  wire [15:0] rd_mux =
    ADDR_I == OFS_DC_BRAKE ? dc_brake_voltage_setting_reg :
    ADDR_I == OFS_MOTOR ? applied_motor_select_reg :
    ADDR_I == OFS_REGEN_SEL ? regen_function_select_reg :
    ADDR_I == OFS_SPEC_DUTY ? special_regen_duty_reg :
    ADDR_I == OFS_STOP_SEL ? stop_method_select_reg :
    ADDR_I == OFS_TERM_SEL ? output_terminal_function_select_reg :
    ADDR_I == OFS_USER_GRP ? user_group_read_select_reg :
    ADDR_I == OFS_STATUS ? {12'h000, status_reg} :
    ADDR_I == OFS_MASK ? {12'h000, mask_reg} :
    ADDR_I == OFS_STATE ? {13'h0000, state_reg} : 16'h0000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) RDATA_O <= 16'h0000;
    else RDATA_O <= RD_I ? rd_mux : 16'h0000;
  end

  assign IRQ_O = |(status_reg & mask_reg);

  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);

  property p_brake_down;
    wr_motor && RATING_MID_I && dc_brake_voltage_setting_reg == PCT_4 &&
      is_std(applied_motor_select_reg) && is_ct(WDATA_I) |=>
      dc_brake_voltage_setting_reg == PCT_2;
  endproperty
  a_brake_down: assert property (p_brake_down) else $error("brake not lowered");
  property p_brake_up;
    wr_motor && RATING_MID_I && dc_brake_voltage_setting_reg == PCT_2 &&
      is_ct(applied_motor_select_reg) && is_std(WDATA_I) |=>
      dc_brake_voltage_setting_reg == PCT_4;
  endproperty
  a_brake_up: assert property (p_brake_up) else $error("brake not raised");
  property p_fixed_duty;
    regen_function_select_reg == 16'h0000 |-> duty_eff == fixed_duty;
  endproperty
  a_fixed_duty: assert property (p_fixed_duty) else $error("fixed duty not used");
  property p_duty_range;
    special_regen_duty_reg <= PCT_MAX && regen_function_select_reg <= REGEN_SEL_MAX;
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("setting out of range");
  property p_alarm_out;
    duty_st.alarm |=> REGEN_DUTY_ALARM_OUT_O;
  endproperty
  a_alarm_out: assert property (p_alarm_out) else $error("alarm not output");
  property p_panel_off;
    regen_function_select_reg == 16'h0000 && $past(regen_function_select_reg) == 16'h0000
      |-> !REGEN_DUTY_PANEL_INDICATION_O;
  endproperty
  a_panel_off: assert property (p_panel_off) else $error("panel shown in mode 0");
  property p_no_trip;
    state_reg == ST_RUN && start && !fault && !override |=> state_reg == ST_RUN;
  endproperty
  a_no_trip: assert property (p_no_trip) else $error("run left without cause");
  property p_term_pos;
    output_terminal_function_select_reg == TERM_POS ##1
      output_terminal_function_select_reg == TERM_POS |->
      OPEN_COLLECTOR_OUTPUT_TERMINAL_O == $past(duty_st.alarm);
  endproperty
  a_term_pos: assert property (p_term_pos) else $error("terminal polarity wrong");
  property p_decel;
    state_reg == ST_RUN && start_fall && sel_decel && !fault |=>
      state_reg == ST_DECEL ##0 DECEL_REQ_O;
  endproperty
  a_decel: assert property (p_decel) else $error("no deceleration stop");
  property p_run_off;
    shutoff |=> !RUN_STATUS_O && !OUTPUT_ENABLE_O;
  endproperty
  a_run_off: assert property (p_run_off) else $error("run status held at shutoff");
  property p_override;
    state_reg == ST_DELAY && override && !fault |=> state_reg == ST_DECEL;
  endproperty
  a_override: assert property (p_override) else $error("override ignored");
  property p_restart;
    state_reg == ST_COAST && start && !fault |=> RESTART_START_FREQ_O ##1 !RESTART_START_FREQ_O;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart from start freq");
  property p_lock;
    wr_stop && !unlocked |=> $stable(stop_method_select_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked setting changed");
  c_coast: cover property (state_reg == ST_DELAY ##1 state_reg == ST_COAST);
  c_alarm: cover property ($rose(REGEN_DUTY_ALARM_OUT_O));
  c_restart: cover property ($rose(RESTART_START_FREQ_O));
endmodule // bsc_top

// *** testbench/tb_bsc_top.sv ***
// Self-checking bench for the brake and stop selection control
`timescale 1ns/10ps
module tb_bsc_top;
  import bsc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} bsc_row_t;
  logic clk = 1'b0, rst_n = 1'b0, wrs = 1'b0, rds = 1'b0, mid = 1'b0, fwd = 1'b0, rev = 1'b0;
  logic pnl = 1'b0, stp = 1'b0, rga = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000, rdat, v;
  logic oen, run, dec, ff, rsf, alm, pind, flt, term, irq;
  int fails = 0, tests_run = 0, cnt;
  // Ordinary register cases: refused writes must leave the last good value
  bsc_row_t rows [15] = '{'{OFS_DC_BRAKE, 16'h001E, 16'h001E}, '{OFS_DC_BRAKE, 16'h001F, 16'h001E},
    '{OFS_SPEC_DUTY, 16'h001E, 16'h001E}, '{OFS_SPEC_DUTY, 16'h001F, 16'h001E},
    '{OFS_REGEN_SEL, 16'h0001, 16'h0001}, '{OFS_REGEN_SEL, 16'h0002, 16'h0001},
    '{OFS_STOP_SEL, 16'h0064, 16'h0064}, '{OFS_STOP_SEL, 16'h0065, 16'h0064},
    '{OFS_STOP_SEL, 16'h03E8, 16'h03E8}, '{OFS_STOP_SEL, 16'h044C, 16'h044C},
    '{OFS_STOP_SEL, 16'h22B8, 16'h22B8}, '{OFS_STOP_SEL, 16'h03E7, 16'h22B8},
    '{OFS_STOP_SEL, 16'h270F, 16'h270F}, '{OFS_TERM_SEL, 16'h006B, 16'h006B},
    '{8'h30, 16'h1234, 16'h0000}};
  always #5 clk = ~clk;
  bsc_top #(.TICK_CYCLES(4)) dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wd),
    .WR_I(wrs), .RD_I(rds), .RDATA_O(rdat), .RATING_MID_I(mid), .MODEL_DUTY2_I(1'b0),
    .FORWARD_START_CMD_I(fwd), .REVERSE_START_CMD_I(rev), .POWER_FAIL_STOP_I(1'b0),
    .PANEL_STOP_I(pnl), .COMM_ERR_STOP_I(1'b0), .MOTOR_STOPPED_I(stp), .REGEN_ACTIVE_I(rga),
    .OUTPUT_ENABLE_O(oen), .RUN_STATUS_O(run), .DECEL_REQ_O(dec), .FREQ_FOLLOW_O(ff),
    .RESTART_START_FREQ_O(rsf), .REGEN_DUTY_ALARM_OUT_O(alm),
    .REGEN_DUTY_PANEL_INDICATION_O(pind), .REGEN_OVERVOLTAGE_FAULT_O(flt),
    .OPEN_COLLECTOR_OUTPUT_TERMINAL_O(term), .IRQ_O(irq));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bus cycles: strobes last one cycle, read data sampled in the cycle after
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wrs <= 1'b1;
    @(posedge clk);
    wrs <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a; rds <= 1'b1;
    @(posedge clk);
    rds <= 1'b0;
    #1 chk(n, e, rdat);
  endtask
  // Bounded wait for a level; the caller compares afterwards
  task automatic wait_hi(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) cyc(1);
  endtask
  task automatic finish_test();
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run is about 8300 cycles; this cuts a hang
  initial begin
    #600us;
    fails++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk("oen_rst", 0, oen);
    rchk("brake_rst", OFS_DC_BRAKE, RST_DC_BRAKE);
    rchk("duty_rst", OFS_SPEC_DUTY, 16'h0000);
    rchk("stop_rst", OFS_STOP_SEL, RST_STOP_SEL);
    rchk("term_rst", OFS_TERM_SEL, RST_TERM_SEL);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rchk("reg_row", rows[i].a, rows[i].e);
    end
    // Brake voltage follows the motor type on mid ratings
    mid <= 1'b1;
    wr(OFS_DC_BRAKE, PCT_4);
    wr(OFS_MOTOR, 16'h0001);
    rchk("brake_ct", OFS_DC_BRAKE, PCT_2);
    wr(OFS_MOTOR, 16'h0000);
    rchk("brake_std", OFS_DC_BRAKE, PCT_4);
    // Locked settings refuse writes and flag it once
    wr(OFS_USER_GRP, 16'h0001);
    wr(OFS_DC_BRAKE, 16'h000A);
    rchk("brake_lock", OFS_DC_BRAKE, PCT_4);
    rchk("st_refuse", OFS_STATUS, 16'h0008);
    rchk("st_clear", OFS_STATUS, 16'h0000);
    wr(OFS_USER_GRP, 16'h0000);
    // Decelerating stop
    wr(OFS_STOP_SEL, STOP_DECEL_A);
    @(posedge clk) fwd <= 1'b1;
    cyc(3);
    chk("run_on", 1, run);
    @(posedge clk) fwd <= 1'b0;
    cyc(3);
    chk("decel", 1, dec);
    @(posedge clk) stp <= 1'b1;
    cyc(3);
    rchk("idle", OFS_STATE, 16'h0000);
    @(posedge clk) stp <= 1'b0;
    // Coast delays of one second in both encodings, then restart from coasting
    foreach (rows[i]) if (i < 2) begin
      wr(OFS_STOP_SEL, (i == 0) ? 16'h0001 : 16'h03E9);
      @(posedge clk) rev <= 1'b1;
      cyc(3);
      @(posedge clk) rev <= 1'b0;
      cyc(1);
      cnt = 0;
      while (oen === 1'b1 && cnt < 6000) begin
        cnt++;
        cyc(1);
        if (cnt == 2000) chk("follow", 1, ff);
      end
      chk("delay", 1, (cnt >= 3990 && cnt <= 4016));
      chk("run_off", 0, run);
      @(posedge clk) fwd <= 1'b1;
      wait_hi(rsf, 8);
      chk("restart", 1, rsf);
      cyc(2);
      @(posedge clk) fwd <= 1'b0;
    end
    // Panel stop overrides the coast delay
    wr(OFS_STOP_SEL, 16'h0001);
    @(posedge clk) pnl <= 1'b1;
    cyc(3);
    chk("override", 1, dec);
    @(posedge clk) stp <= 1'b1;
    pnl <= 1'b0;
    cyc(3);
    @(posedge clk) stp <= 1'b0;
    // Duty alarm at 85 percent of 10 percent, then the fault at full duty
    wr(OFS_MASK, 16'h0001);
    wr(OFS_REGEN_SEL, 16'h0001);
    wr(OFS_SPEC_DUTY, 16'h000A);
    wr(OFS_TERM_SEL, TERM_POS);
    @(posedge clk) fwd <= 1'b1;
    rga <= 1'b1;
    wait_hi(alm, 200);
    rga <= 1'b0;
    chk("alarm", 1, alm);
    chk("no_fault", 0, flt);
    cyc(2);
    chk("panel", 1, pind);
    chk("term_pos", 1, term);
    chk("irq", 1, irq);
    chk("no_trip", 1, oen);
    wr(OFS_TERM_SEL, TERM_NEG);
    cyc(2);
    chk("term_neg", 0, term);
    // Shutoff bit from the two coast stops is still pending beside the alarm rise
    rchk("st_alarm", OFS_STATUS, 16'h0005);
    chk("irq_clr", 0, irq);
    @(posedge clk) rga <= 1'b1;
    wait_hi(flt, 40);
    chk("fault", 1, flt);
    wr(OFS_REGEN_SEL, 16'h0000);
    cyc(3);
    chk("panel_off", 0, pind);
    chk("trip", 0, oen);
    // Reset while coasting after the fault trip clears the sticky fault
    @(posedge clk) rst_n <= 1'b0;
    cyc(2);
    chk("flt_rst", 0, flt);
    finish_test();
  end
endmodule // tb_bsc_top
